/* File: eppx_pkg.sv */
package eppx_pkg;
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_STATUS = 3'h1;
	localparam logic [2:0] ADDR_CONTROL = 3'h2;
	localparam logic [2:0] ADDR_REMOTE_ADDR = 3'h3;
	localparam logic [2:0] ADDR_REMOTE_D0 = 3'h4;
	localparam logic [2:0] ADDR_REMOTE_D1 = 3'h5;
	localparam logic [2:0] ADDR_REMOTE_D2 = 3'h6;
	localparam logic [2:0] ADDR_REMOTE_D3 = 3'h7;
	localparam logic [7:0] CONTROL_RESET = 8'h04;
	localparam int CTL_IRQ_EN_BIT = 4;
	localparam int CTL_DIR_BIT = 5;
	localparam logic [1:0] CTL_RESERVED = 2'h3;
	localparam int TIMEOUT_NS = 10000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int TIMEOUT_CYCLES = TIMEOUT_NS / CLK_PERIOD_NS;
	localparam logic [1:0] BYTES_ONE = 2'h0;
	localparam logic [1:0] BYTES_TWO = 2'h1;
	localparam logic [1:0] BYTES_FOUR = 2'h3;
	typedef enum logic [1:0] {
		EPPX_REV17,
		EPPX_REV19,
		EPPX_REVRSV0,
		EPPX_REVRSV1
	} eppx_rev_type;
endpackage : eppx_pkg

/* File: eppx_engine.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Writing the data register sets the eight port data lines.
// - Status register is read-only: live five status pins plus interrupt state.
// - Control write sets four control pins, interrupt enable and direction.
// - Address register read/write; a write starts an address strobe cycle.
// - Any access to data byte 0 starts a peripheral data cycle, bits 7..0.
// - Data byte 1 is a local register only; no access width sends it out.
// - Bytes 2 and 3 are local registers too; sys_width_i is never used.
// - Rev 1.7 write latches byte, lowers write, then drives lines and strobe together.
// - Rev 1.7 holds ready low while wait is low, else never lowers it.
// - Rev 1.7 write end: strobe rises, then write; data changes only then.
// - Rev 1.7 read: strobe low on read, high after, then bus released.
// - Rev 1.7 data cycles use the data strobe and data registers.
// - Zero-wait write: write line, strobe, then zws low if wait high.
// - Zero-wait write end: strobe, then zws, then write line rise.
// - Wait falling early turns zero-wait into a normal wait-state cycle.
// - Zero-wait read mirrors write, data inward, write line stays high.
// - Zero-wait data cycles use data strobe and a data register.
// - Rev 1.9 write: ready low and data out, wait for wait low, then write and strobe.
// - Rev 1.9 write: strobe until wait high, release ready, strobe off, wr high.
// - Rev 1.9 after wait low: raise write unless another write is pending.
// - Rev 1.9 read: ready low, strobe until wait high, latch on read end.
// - Rev 1.9 data cycles use data strobe and data registers.
// - Ready low beyond 10 us aborts cycle, drops strobe, sets timeout status.
module eppx_engine
#(
	parameter int TIMEOUT_COUNT = eppx_pkg::TIMEOUT_CYCLES
)(
	input  wire logic              mclk_i,
	input  wire logic              reset_i,
	input  wire logic              clk_en_i,
	input  wire logic              rev19_sel_i,
	input  wire logic              zws_enable_i,
	input  wire logic [2:0]        sys_addr_i,
	input  wire logic              sys_rd_n_i,
	input  wire logic              sys_wr_n_i,
	input  wire logic [1:0]        sys_width_i,
	input  wire logic [7:0]        system_data_bus_i,
	output logic      [7:0]        system_data_bus_o,
	output logic                   system_data_bus_oe_o,
	output logic                   iochrdy_o,
	output logic                   zws_n_o,
	input  wire logic              wait_n_i,
	input  wire logic [4:0]        status_pins_i,
	input  wire logic              irq_state_i,
	input  wire logic [7:0]        port_data_lines_i,
	output logic      [7:0]        port_data_lines_o,
	output logic                   port_data_lines_oe_o,
	output logic      [3:0]        control_pins_o,
	output logic                   write_n_o,
	output logic                   address_strobe_n_o,
	output logic                   data_strobe_n_o,
	output logic                   irq_enable_o,
	output logic                   timeout_o
);
	import eppx_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_WAIT_END,
		ST_RELEASE,
		ST_HOLD_LOW
	} eppx_state_type;

	eppx_state_type state_reg;
	logic [1:0]  rd_sync_reg;
	logic [1:0]  wr_sync_reg;
	logic [1:0]  wait_sync_reg;
	logic [4:0]  stat_sync0_reg;
	logic [4:0]  stat_sync1_reg;
	logic [7:0]  pin_sync0_reg;
	logic [7:0]  pin_sync1_reg;
	logic [2:0]  addr_sync0_reg;
	logic [2:0]  addr_sync1_reg;
	logic [1:0]  width_sync0_reg;
	logic [1:0]  width_sync1_reg;
	logic [7:0]  sdat_sync0_reg;
	logic [7:0]  sdat_sync1_reg;
	logic        rd_prev_reg;
	logic        wr_prev_reg;
	logic [7:0]  port_data_reg;
	logic [7:0]  control_reg;
	logic [7:0]  remote_address_reg;
	logic [7:0]  remote_data_reg [4];
	logic        timeout_reg;
	logic [7:0]  out_byte_reg;
	logic        is_write_reg;
	logic        is_addr_reg;
	logic [2:0]  cyc_addr_reg;
	logic        strobe_reg;
	logic        write_line_reg;
	logic        ready_low_reg;
	logic        zws_reg;
	logic        zws_try_reg;
	logic [31:0] tmo_cnt_reg;

	logic rd_low;
	logic wr_low;
	logic wait_low;
	logic acc_start;
	logic wr_start;
	logic remote_acc;
	logic sys_done;

	// The asynchronous bus strobes and the cable inputs are resynchronised.
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rd_sync_reg     <= 2'h3;
			wr_sync_reg     <= 2'h3;
			wait_sync_reg   <= 2'h3;
			stat_sync0_reg  <= 5'h00;
			stat_sync1_reg  <= 5'h00;
			pin_sync0_reg   <= 8'h00;
			pin_sync1_reg   <= 8'h00;
			addr_sync0_reg  <= 3'h0;
			addr_sync1_reg  <= 3'h0;
			width_sync0_reg <= 2'h0;
			width_sync1_reg <= 2'h0;
			sdat_sync0_reg  <= 8'h00;
			sdat_sync1_reg  <= 8'h00;
			rd_prev_reg     <= 1'b1;
			wr_prev_reg     <= 1'b1;
		end
		else if (clk_en_i)
		begin
			rd_sync_reg     <= {rd_sync_reg[0], sys_rd_n_i};
			wr_sync_reg     <= {wr_sync_reg[0], sys_wr_n_i};
			wait_sync_reg   <= {wait_sync_reg[0], wait_n_i};
			stat_sync0_reg  <= status_pins_i;
			stat_sync1_reg  <= stat_sync0_reg;
			pin_sync0_reg   <= port_data_lines_i;
			pin_sync1_reg   <= pin_sync0_reg;
			addr_sync0_reg  <= sys_addr_i;
			addr_sync1_reg  <= addr_sync0_reg;
			width_sync0_reg <= sys_width_i;
			width_sync1_reg <= width_sync0_reg;
			sdat_sync0_reg  <= system_data_bus_i;
			sdat_sync1_reg  <= sdat_sync0_reg;
			rd_prev_reg     <= rd_sync_reg[1];
			wr_prev_reg     <= wr_sync_reg[1];
		end
	end

	assign rd_low     = ~rd_sync_reg[1];
	assign wr_low     = ~wr_sync_reg[1];
	assign wait_low   = ~wait_sync_reg[1];
	assign wr_start   = wr_prev_reg & wr_low;
	assign acc_start  = (rd_prev_reg & rd_low) | wr_start;
	// Bytes 1..3 are local registers only; an access to them starts no cycle.
	assign remote_acc = (addr_sync1_reg == ADDR_REMOTE_ADDR) ||
		(addr_sync1_reg == ADDR_REMOTE_D0);
	assign sys_done   = is_write_reg ? ~wr_low : ~rd_low;

	// Local registers; the timeout flag is set by hardware and cleared when a
	// status read ends, so that read still returns it; a set in that cycle wins.
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			port_data_reg      <= 8'h00;
			control_reg        <= CONTROL_RESET;
			remote_address_reg <= 8'h00;
			timeout_reg        <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (wr_start && addr_sync1_reg == ADDR_DATA)
				port_data_reg <= sdat_sync1_reg;
			if (wr_start && addr_sync1_reg == ADDR_CONTROL)
				control_reg <= sdat_sync1_reg;
			if (wr_start && addr_sync1_reg == ADDR_REMOTE_ADDR)
				remote_address_reg <= sdat_sync1_reg;
			if (state_reg != ST_IDLE && tmo_cnt_reg >= 32'(TIMEOUT_COUNT))
				timeout_reg <= 1'b1;
			else if (!rd_prev_reg && !rd_low && addr_sync1_reg == ADDR_STATUS)
				timeout_reg <= 1'b0;
		end
	end

	// Data byte lanes: one entry per lane, written by the system or latched
	// from the cable at the end of a read on lane 0, the only lane that starts a cycle.
	for (genvar g = 0; g < 4; g++)
	begin : g_lane
		always_ff @(posedge mclk_i or posedge reset_i)
		begin
			if (reset_i)
				remote_data_reg[g] <= 8'h00;
			else if (clk_en_i)
			begin
				if (wr_start && addr_sync1_reg == 3'(ADDR_REMOTE_D0 + 3'(g)))
					remote_data_reg[g] <= sdat_sync1_reg;
				else if (state_reg == ST_WAIT_END && !is_write_reg && !is_addr_reg
					&& !rd_low && cyc_addr_reg == 3'(ADDR_REMOTE_D0 + 3'(g)))
					remote_data_reg[g] <= pin_sync1_reg;
			end
		end
	end

	// Transfer engine for address and data cycles in both revisions.
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_reg      <= ST_IDLE;
			out_byte_reg   <= 8'h00;
			is_write_reg   <= 1'b0;
			is_addr_reg    <= 1'b0;
			cyc_addr_reg   <= 3'h0;
			strobe_reg     <= 1'b0;
			write_line_reg <= 1'b0;
			ready_low_reg  <= 1'b0;
			zws_reg        <= 1'b0;
			zws_try_reg    <= 1'b0;
			tmo_cnt_reg    <= 32'h0000_0000;
		end
		else if (clk_en_i)
		begin
			if (ready_low_reg)
				tmo_cnt_reg <= tmo_cnt_reg + 32'h0000_0001;
			else
				tmo_cnt_reg <= 32'h0000_0000;
			if (state_reg != ST_IDLE && tmo_cnt_reg >= 32'(TIMEOUT_COUNT))
			begin
				strobe_reg    <= 1'b0;
				ready_low_reg <= 1'b0;
				zws_reg       <= 1'b0;
				state_reg     <= ST_WAIT_END;
			end
			else
			begin
				unique case (state_reg)
					ST_IDLE:
					begin
						if (acc_start && remote_acc)
						begin
							is_write_reg <= wr_start;
							is_addr_reg  <= (addr_sync1_reg == ADDR_REMOTE_ADDR);
							cyc_addr_reg <= addr_sync1_reg;
							if (wr_start)
								out_byte_reg <= sdat_sync1_reg;
							zws_try_reg  <= zws_enable_i;
							if (rev19_sel_i)
							begin
								ready_low_reg <= 1'b1;
								state_reg     <= ST_HOLD_LOW;
							end
							else
							begin
								write_line_reg <= wr_start;
								state_reg      <= ST_SETUP;
							end
						end
					end
					ST_HOLD_LOW:
					begin
						if (wait_low)
						begin
							write_line_reg <= is_write_reg;
							strobe_reg     <= 1'b1;
							state_reg      <= ST_STROBE;
						end
					end
					ST_SETUP:
					begin
						strobe_reg <= 1'b1;
						state_reg  <= ST_STROBE;
					end
					ST_STROBE:
					begin
						if (rev19_sel_i)
						begin
							if (!wait_low)
							begin
								ready_low_reg <= 1'b0;
								state_reg     <= ST_WAIT_END;
							end
						end
						else if (wait_low)
						begin
							zws_reg       <= 1'b0;
							zws_try_reg   <= 1'b0;
							ready_low_reg <= 1'b1;
						end
						else
						begin
							ready_low_reg <= 1'b0;
							zws_reg       <= zws_try_reg & ~ready_low_reg;
							if (sys_done)
								state_reg <= ST_WAIT_END;
						end
					end
					ST_WAIT_END:
					begin
						if (sys_done)
						begin
							strobe_reg <= 1'b0;
							state_reg  <= ST_RELEASE;
						end
					end
					ST_RELEASE:
					begin
						if (zws_reg)
							zws_reg <= 1'b0;
						else if (!rev19_sel_i || !is_write_reg || wait_low)
						begin
							// Keeping the write line low saves a turnaround
							// when the next system write is already waiting.
							if (!(rev19_sel_i && wr_low && is_write_reg))
								write_line_reg <= 1'b0;
							state_reg <= ST_IDLE;
						end
					end
					default:
						state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// The port data lines follow the transfer byte only while a transfer owns
	// them, otherwise the legacy data register; both lines high on change.
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
			port_data_lines_o <= 8'h00;
		else if (clk_en_i && !strobe_reg)
			port_data_lines_o <= (state_reg == ST_IDLE) ? port_data_reg : out_byte_reg;
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			system_data_bus_o    <= 8'h00;
			system_data_bus_oe_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			system_data_bus_oe_o <= (rd_low && state_reg != ST_RELEASE) ||
				(strobe_reg && !is_write_reg);
			unique case (addr_sync1_reg)
				ADDR_DATA:        system_data_bus_o <= port_data_reg;
				ADDR_STATUS:      system_data_bus_o <= {stat_sync1_reg, irq_state_i,
					1'b0, timeout_reg};
				ADDR_CONTROL:     system_data_bus_o <= {CTL_RESERVED, control_reg[5:0]};
				ADDR_REMOTE_ADDR: system_data_bus_o <= (state_reg == ST_IDLE) ?
					remote_address_reg : pin_sync1_reg;
				default:          system_data_bus_o <= (state_reg == ST_IDLE) ?
					remote_data_reg[2'(addr_sync1_reg - ADDR_REMOTE_D0)] : pin_sync1_reg;
			endcase
		end
	end

	// Pins that transfers drive assume software has parked them as required.
	assign control_pins_o       = control_reg[3:0];
	assign irq_enable_o         = control_reg[CTL_IRQ_EN_BIT];
	assign port_data_lines_oe_o = ~control_reg[CTL_DIR_BIT] &
		~(state_reg != ST_IDLE && !is_write_reg);
	assign write_n_o            = ~write_line_reg;
	assign address_strobe_n_o   = ~(strobe_reg & is_addr_reg);
	assign data_strobe_n_o      = ~(strobe_reg & ~is_addr_reg);
	assign iochrdy_o            = ~ready_low_reg;
	assign zws_n_o              = ~zws_reg;
	assign timeout_o            = timeout_reg;

	a_strobe_order: assert property (@(posedge mclk_i) disable iff (reset_i)
		$fell(write_n_o) |-> ##[0:8] (!address_strobe_n_o || !data_strobe_n_o)
		or (state_reg == ST_HOLD_LOW)) else $error("strobe did not follow write");
	a_write_after: assert property (@(posedge mclk_i) disable iff (reset_i)
		$rose(write_n_o) |-> address_strobe_n_o && data_strobe_n_o)
		else $error("write line rose under strobe");
	a_zws_ready: assert property (@(posedge mclk_i) disable iff (reset_i)
		!zws_n_o |-> iochrdy_o) else $error("zws with ready low");
	a_timeout_set: assert property (@(posedge mclk_i) disable iff (reset_i)
		clk_en_i && state_reg != ST_IDLE && tmo_cnt_reg >= 32'(TIMEOUT_COUNT)
		|=> timeout_o && iochrdy_o) else $error("timeout not taken");
	a_rev19_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
		state_reg == ST_HOLD_LOW |-> !iochrdy_o) else $error("ready not held");
	a_data_stable: assert property (@(posedge mclk_i) disable iff (reset_i)
		!address_strobe_n_o && $past(!address_strobe_n_o) |-> $stable(port_data_lines_o))
		else $error("data changed under strobe");
	a_one_strobe: assert property (@(posedge mclk_i) disable iff (reset_i)
		!(~address_strobe_n_o && ~data_strobe_n_o)) else $error("two strobes");
	a_read_write: assert property (@(posedge mclk_i) disable iff (reset_i)
		state_reg != ST_IDLE && !is_write_reg |-> write_n_o)
		else $error("write line low in read");
	a_read_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
		$rose(address_strobe_n_o) && !is_write_reg |-> system_data_bus_oe_o)
		else $error("system bus freed before strobe rose");
endmodule : eppx_engine
`default_nettype wire

/* File: eppx_periph_model.sv */
`timescale 1ns/1ns
`default_nettype none
module eppx_periph_model (
	input  wire logic       mclk_i,
	input  wire logic       reset_i,
	input  wire logic       fast_i,
	input  wire logic       stuck_i,
	input  wire logic       write_n_i,
	input  wire logic       address_strobe_n_i,
	input  wire logic       data_strobe_n_i,
	input  wire logic [7:0] pd_i,
	input  wire logic [7:0] reply_i,
	output logic            wait_n_o,
	output logic      [7:0] pd_o,
	output logic            pd_oe_o,
	output logic      [7:0] addr_o,
	output logic      [7:0] data_o
);
	logic       sel;
	logic [1:0] cnt_reg;
	logic       as_reg;
	logic       ds_reg;
	assign sel = !address_strobe_n_i || !data_strobe_n_i;
	assign pd_oe_o = sel && write_n_i;
	assign pd_o = reply_i;
	// A slow peripheral answers four cycles into a strobe; stuck never answers.
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cnt_reg <= 2'h0;
			wait_n_o <= 1'b0;
		end
		else if (fast_i)
			wait_n_o <= 1'b1;
		else if (!sel)
		begin
			cnt_reg <= 2'h0;
			wait_n_o <= 1'b0;
		end
		else if (!stuck_i && cnt_reg == 2'h3)
			wait_n_o <= 1'b1;
		else
			cnt_reg <= cnt_reg + 2'h1;
	end
	// Bytes are taken at the strobe's rising edge, when the lines are known stable.
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			as_reg <= 1'b1;
			ds_reg <= 1'b1;
			addr_o <= 8'h00;
			data_o <= 8'h00;
		end
		else
		begin
			as_reg <= address_strobe_n_i;
			ds_reg <= data_strobe_n_i;
			if (!as_reg && address_strobe_n_i && !write_n_i)
				addr_o <= pd_i;
			if (!ds_reg && data_strobe_n_i && !write_n_i)
				data_o <= pd_i;
		end
	end
endmodule : eppx_periph_model
`default_nettype wire

/* File: epp_parallel_transfer_engine_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHECK(g, e) check_val((g), (e))
module epp_parallel_transfer_engine_tb;
	import eppx_pkg::*;
	logic       mclk_i = 0, reset_i = 1, clk_en_i = 1, rev19 = 0, zws_en = 0;
	logic [2:0] sys_addr_i = 0;
	logic       rd_n = 1, wr_n = 1, irq_state_i = 1, fast = 0, stuck = 0;
	logic [1:0] sys_width_i = 0;
	logic [7:0] sys_d = 0, bus_o, pd_o, m_pd, reply = 0, m_addr, m_data, pd_w, pd_last = 0, q, q2;
	logic [4:0] status_pins_i = 0;
	logic       bus_oe, iochrdy_o, zws_n_o, wait_n, pd_oe, m_oe, write_n_o, as_n, ds_n, irq_en;
	logic       timeout_o;
	logic [3:0] ctl_pins;
	int         n_errors = 0, tests_run = 0, k;
	int         cnt[5] = '{default: 0};
	int         s[5];
	always #2 mclk_i = ~mclk_i;
	assign pd_w = pd_oe ? pd_o : m_oe ? m_pd : ~pd_last;
	eppx_engine #(.TIMEOUT_COUNT(20)) dut (.mclk_i(mclk_i), .reset_i(reset_i),
		.clk_en_i(clk_en_i), .rev19_sel_i(rev19), .zws_enable_i(zws_en),
		.sys_addr_i(sys_addr_i), .sys_rd_n_i(rd_n), .sys_wr_n_i(wr_n),
		.sys_width_i(sys_width_i), .system_data_bus_i(sys_d), .system_data_bus_o(bus_o),
		.system_data_bus_oe_o(bus_oe), .iochrdy_o(iochrdy_o), .zws_n_o(zws_n_o),
		.wait_n_i(wait_n), .status_pins_i(status_pins_i), .irq_state_i(irq_state_i),
		.port_data_lines_i(pd_w), .port_data_lines_o(pd_o), .port_data_lines_oe_o(pd_oe),
		.control_pins_o(ctl_pins), .write_n_o(write_n_o), .address_strobe_n_o(as_n),
		.data_strobe_n_o(ds_n), .irq_enable_o(irq_en), .timeout_o(timeout_o));
	eppx_periph_model peer (.mclk_i(mclk_i), .reset_i(reset_i), .fast_i(fast),
		.stuck_i(stuck), .write_n_i(write_n_o), .address_strobe_n_i(as_n),
		.data_strobe_n_i(ds_n), .pd_i(pd_w), .reply_i(reply), .wait_n_o(wait_n),
		.pd_o(m_pd), .pd_oe_o(m_oe), .addr_o(m_addr), .data_o(m_data));
	// Counts: ready-low cycles, zws-low cycles, write-low cycles, address and data strobe falls.
	logic as_q = 1, ds_q = 1;
	always @(posedge mclk_i)
	begin
		pd_last <= pd_w;
		as_q <= as_n;
		ds_q <= ds_n;
		if (iochrdy_o !== 1'b1) cnt[0]++;
		if (zws_n_o !== 1'b1) cnt[1]++;
		if (write_n_o !== 1'b1) cnt[2]++;
		if (as_q && !as_n) cnt[3]++;
		if (ds_q && !ds_n) cnt[4]++;
	end
	function automatic int d(input int i);
		return cnt[i] - s[i];
	endfunction : d
	task automatic check_val(input logic [127:0] g, input logic [127:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check_val
	// The cycle is held until ready is seen high, as the system bus would.
	task automatic acc(input logic [2:0] a, input logic wr, input logic [7:0] v);
		s = cnt;
		@(posedge mclk_i);
		sys_addr_i <= a;
		sys_d <= v;
		if (wr) wr_n <= 1'b0;
		else rd_n <= 1'b0;
		repeat (8) @(posedge mclk_i);
		for (k = 0; k < 200 && iochrdy_o !== 1'b1; k++) @(posedge mclk_i);
		if (k == 200) `CHECK(0, 1);
		q = bus_o;
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (16) @(posedge mclk_i);
	endtask : acc
	task automatic t_local;
		acc(ADDR_CONTROL, 1, 8'h3b);
		`CHECK({irq_en, ctl_pins, pd_oe}, 6'h36);
		acc(ADDR_CONTROL, 0, 0);
		`CHECK(q, 8'hfb);
		acc(ADDR_CONTROL, 1, 8'h04);
		acc(ADDR_DATA, 1, 8'ha5);
		`CHECK({pd_oe, pd_o}, 9'h1a5);
		acc(ADDR_STATUS, 1, 8'hff);
		acc(ADDR_STATUS, 0, 0);
		`CHECK(q[2:0], 3'h4);
		status_pins_i <= 5'h1f;
		acc(ADDR_STATUS, 0, 0);
		`CHECK(q, 8'hfc);
		q2 = q;
		status_pins_i <= 5'h00;
		acc(ADDR_STATUS, 0, 0);
		`CHECK((q ^ q2) & 8'hf8, 8'hf8);
		$display("local registers done");
	endtask : t_local
	task automatic t_rev17;
		acc(ADDR_REMOTE_ADDR, 1, 8'h3c);
		`CHECK(m_addr, 8'h3c);
		`CHECK(d(0) > 0, 1);
		`CHECK({d(3), d(4)}, {32'd1, 32'd0});
		`CHECK({write_n_o, as_n, iochrdy_o}, 3'h7);
		acc(ADDR_REMOTE_D0, 1, 8'h96);
		`CHECK({m_data, d(4), d(3)}, {8'h96, 32'd1, 32'd0});
		for (int a = 5; a < 8; a++)
		begin
			acc(3'(a), 1, 8'h11);
			`CHECK(d(3) + d(4), 0);
		end
		acc(ADDR_REMOTE_D3, 0, 0);
		`CHECK(q, 8'h11);
		reply <= 8'h71;
		acc(ADDR_REMOTE_ADDR, 0, 0);
		`CHECK({q, d(3), d(2)}, {8'h71, 32'd1, 32'd0});
		`CHECK({bus_oe, as_n}, 2'h1);
		$display("rev 1.7 done");
	endtask : t_rev17
	task automatic t_zws;
		fast <= 1'b1;
		acc(ADDR_REMOTE_D0, 1, 8'h5e);
		`CHECK({d(0), d(1)}, {32'd0, 32'd0});
		zws_en <= 1'b1;
		acc(ADDR_REMOTE_D0, 1, 8'h5a);
		`CHECK(d(1) > 0, 1);
		`CHECK({m_data, d(0), d(4)}, {8'h5a, 32'd0, 32'd1});
		`CHECK({write_n_o, ds_n, zws_n_o}, 3'h7);
		reply <= 8'hc3;
		acc(ADDR_REMOTE_D0, 0, 0);
		`CHECK({q, d(2), d(1) > 0}, {8'hc3, 32'd0, 1'b1});
		fast <= 1'b0;
		acc(ADDR_REMOTE_D0, 1, 8'h69);
		`CHECK({d(0) > 0, m_data, d(1)}, {1'b1, 8'h69, 32'd0});
		zws_en <= 1'b0;
		$display("zero wait done");
	endtask : t_zws
	task automatic t_rev19;
		rev19 <= 1'b1;
		acc(ADDR_REMOTE_D0, 1, 8'he1);
		`CHECK({m_data, d(0) > 0, d(4)}, {8'he1, 1'b1, 32'd1});
		`CHECK({write_n_o, ds_n}, 2'h3);
		reply <= 8'h2b;
		acc(ADDR_REMOTE_ADDR, 0, 0);
		`CHECK({q, d(3), d(2)}, {8'h2b, 32'd1, 32'd0});
		`CHECK({bus_oe, as_n}, 2'h1);
		stuck <= 1'b1;
		acc(ADDR_REMOTE_ADDR, 1, 8'h44);
		`CHECK({timeout_o, as_n, iochrdy_o, write_n_o}, 4'hf);
		stuck <= 1'b0;
		acc(ADDR_STATUS, 0, 0);
		`CHECK(q[0], 1'b1);
		acc(ADDR_STATUS, 0, 0);
		`CHECK(q[0], 1'b0);
		rev19 <= 1'b0;
		$display("rev 1.9 done");
	endtask : t_rev19
	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	initial
	begin
		repeat (4) @(posedge mclk_i);
		reset_i <= 1'b0;
		t_local;
		t_rev17;
		t_zws;
		t_rev19;
		results;
	end
	initial
	begin
		#80000;
		n_errors++;
		results;
	end
endmodule : epp_parallel_transfer_engine_tb
`default_nettype wire
